// ---- common/wds_pkg.sv ----
//
// Purpose: shared constants for the dead-band and shutdown control block
// Assumes: 32-bit AXI4-Lite register access, one clock domain
// Notes:   byte addresses, field positions and reset values live here
//
// Functional notes
// - six-bit rising dead-band count in bits 5:0, delays after rising input
// - six-bit falling dead-band count in bits 5:0, delays after falling input
// - count registers bits 7:6 read zero, writes there ignored
// - count fields undefined at power-up, kept across any other reset
// - bit 6 auto-restart enable leaves shutdown by itself; resets to zero
// - second-pair level 11 drives both second-pair outputs high in shutdown
// - second-pair level 10 drives both second-pair outputs low in shutdown
// - first-pair level bits 3:2: 10 drives low, 01 tri-states pins
// - after status clears, hold shutdown levels until next rising input edge
package wds_pkg;

    // ****************************************
    // bus and register map
    // ****************************************
    localparam int WDS_DATA_W = 32;
    localparam int WDS_ADDR_W = 8;
    localparam logic [7:0] WDS_ADDR_RISE = 8'h00;
    localparam logic [7:0] WDS_ADDR_FALL = 8'h04;
    localparam logic [7:0] WDS_ADDR_SDCTL = 8'h08;
    localparam logic [7:0] WDS_ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] WDS_ADDR_IRQ_MASK = 8'h10;
    localparam logic [1:0] WDS_RESP_OKAY = 2'h0;
    localparam logic [1:0] WDS_RESP_SLVERR = 2'h2;
    localparam logic [31:0] WDS_ZERO_WORD = 32'h0000_0000;

    // ****************************************
    // fields
    // ****************************************
    localparam int WDS_CNT_W = 6;
    localparam int WDS_SD_BIT = 7;
    localparam int WDS_REN_BIT = 6;
    localparam int WDS_LB_LO = 4;
    localparam int WDS_LA_LO = 2;
    localparam int WDS_LVL_W = 2;
    localparam logic [1:0] WDS_LVL_HIGH = 2'h3;
    localparam logic [1:0] WDS_LVL_LOW = 2'h2;
    localparam logic [1:0] WDS_LVL_TRI = 2'h1;
    localparam logic [1:0] WDS_LVL_RST = 2'h1;
    localparam logic WDS_REN_RST = 1'h0;
    localparam int WDS_IRQ_W = 2;
    localparam int WDS_IRQ_SHUT = 0;
    localparam int WDS_IRQ_RESUME = 1;
    localparam logic [1:0] WDS_IRQ_RST = 2'h0;

    typedef enum logic [1:0] {
        WDS_RUN,
        WDS_SHUT,
        WDS_HOLD
    } wds_state_t;

endpackage

// ---- common/wds_db_if.sv ----
//
// Purpose: carries one dead-band channel between control and delay unit
// Assumes: same clock on both sides
// Notes:   level is the edge source, delayed is the dead-banded drive
//
`timescale 1ns/1ps
interface wds_db_if;
    logic level;
    logic [wds_pkg::WDS_CNT_W-1:0] count;
    logic delayed;
    modport ctrl (output level, output count, input delayed);
    modport unit (input level, input count, output delayed);
endinterface

// ---- core/wds_sync.sv ----
//
// Purpose: two-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes:   only the second stage may be read by logic
//
`timescale 1ns/1ps
module wds_sync #(
    parameter int WIDTH = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// ---- core/wds_deadband.sv ----
//
// Purpose: delays the active edge of one drive by a programmed count
// Assumes: count is stable while a delay runs
// Notes:   drive drops at once when the level falls
//
`timescale 1ns/1ps
module wds_deadband (
    input wire logic aclk,
    input wire logic aresetn,
    wds_db_if.unit db
);
    logic level_d_reg;
    logic [wds_pkg::WDS_CNT_W-1:0] cnt_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // track the idle level: an idle-high source gives no false edge
            level_d_reg <= db.level;
            cnt_reg <= '0;
            db.delayed <= 1'h0;
        end else begin
            level_d_reg <= db.level;
            if (db.level && !level_d_reg) begin
                cnt_reg <= db.count;
            end else if (cnt_reg != '0) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
            // edge cycle never drives, so a zero count still gives one cycle
            db.delayed <= db.level && level_d_reg && (cnt_reg == '0);
        end
    end
endmodule

// ---- core/wds_top.sv ----
//
// Purpose: dead-band timing and auto-shutdown control for output pairs
// Assumes: AXI4-Lite master, shutdown request already gated by sources
// Notes:   pins are sampled through two flops before use
//
`timescale 1ns/1ps
module wds_top #(
    parameter int ADDR_W = wds_pkg::WDS_ADDR_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic wave_in,
    input wire logic shutdown_req,
    output logic [1:0] first_output_pair,
    output logic [1:0] first_output_pair_oe,
    output logic [1:0] second_output_pair,
    output logic [1:0] second_output_pair_oe,
    output logic irq
);

    // ****************************************
    // declarations
    // ****************************************
    logic [ADDR_W-1:0] aw_addr_reg;
    logic aw_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_held_reg;
    logic wr_fire;
    logic wr_lane0;
    logic wr_hit;
    logic [7:0] wr_byte;
    logic rd_fire;
    logic rd_hit;
    logic [31:0] rd_word;

    logic [wds_pkg::WDS_CNT_W-1:0] rise_deadband_value_reg;
    logic [wds_pkg::WDS_CNT_W-1:0] fall_deadband_value_reg;
    logic shutdown_reg;
    logic shutdown_next;
    logic restart_en_reg;
    logic [1:0] second_pair_shutdown_level_reg;
    logic [1:0] first_pair_shutdown_level_reg;
    logic [wds_pkg::WDS_IRQ_W-1:0] irq_stat_reg;
    logic [wds_pkg::WDS_IRQ_W-1:0] irq_mask_reg;
    logic [wds_pkg::WDS_IRQ_W-1:0] irq_event;

    logic [1:0] pin_sync;
    logic wave_s;
    logic req_s;
    logic wave_d_reg;
    logic wave_rise;
    wds_pkg::wds_state_t state_reg;
    wds_pkg::wds_state_t state_next;
    logic override;
    logic [1:0] first_lvl;
    logic [1:0] second_lvl;

    wds_db_if rise_db ();
    wds_db_if fall_db ();

    // ****************************************
    // pin synchronisers and dead-band units
    // ****************************************
    wds_sync #(
        .WIDTH(2)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({shutdown_req, wave_in}),
        .sync_out(pin_sync)
    );

    assign wave_s = pin_sync[0];
    assign req_s = pin_sync[1];

    assign rise_db.level = wave_s;
    assign rise_db.count = rise_deadband_value_reg;
    assign fall_db.level = !wave_s;
    assign fall_db.count = fall_deadband_value_reg;

    wds_deadband u_rise (
        .aclk(aclk),
        .aresetn(aresetn),
        .db(rise_db)
    );

    wds_deadband u_fall (
        .aclk(aclk),
        .aresetn(aresetn),
        .db(fall_db)
    );

    // ****************************************
    // write channel
    // ****************************************
    // address and data are taken independently, in either order
    assign awready = !aw_held_reg;
    assign wready = !w_held_reg;
    assign wr_fire = aw_held_reg && w_held_reg && !bvalid;
    assign wr_lane0 = wr_fire && w_strb_reg[0];
    assign wr_byte = w_data_reg[7:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'h0;
            aw_addr_reg <= '0;
        end else if (awvalid && awready) begin
            aw_held_reg <= 1'h1;
            aw_addr_reg <= awaddr;
        end else if (wr_fire) begin
            aw_held_reg <= 1'h0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'h0;
            w_data_reg <= wds_pkg::WDS_ZERO_WORD;
            w_strb_reg <= 4'h0;
        end else if (wvalid && wready) begin
            w_held_reg <= 1'h1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'h0;
        end
    end

    always_comb begin
        unique case (aw_addr_reg)
            wds_pkg::WDS_ADDR_RISE,
            wds_pkg::WDS_ADDR_FALL,
            wds_pkg::WDS_ADDR_SDCTL,
            wds_pkg::WDS_ADDR_IRQ_STAT,
            wds_pkg::WDS_ADDR_IRQ_MASK: wr_hit = 1'h1;
            default: wr_hit = 1'h0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'h0;
            bresp <= wds_pkg::WDS_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'h1;
            bresp <= wr_hit ? wds_pkg::WDS_RESP_OKAY
                            : wds_pkg::WDS_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'h0;
        end
    end

    // ****************************************
    // dead-band count registers
    // ****************************************
    // no reset on purpose: contents survive a bus reset and start unknown
    always_ff @(posedge aclk) begin
        if (wr_lane0 && aw_addr_reg == wds_pkg::WDS_ADDR_RISE) begin
            rise_deadband_value_reg <= wr_byte[wds_pkg::WDS_CNT_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (wr_lane0 && aw_addr_reg == wds_pkg::WDS_ADDR_FALL) begin
            fall_deadband_value_reg <= wr_byte[wds_pkg::WDS_CNT_W-1:0];
        end
    end

    // ****************************************
    // shutdown control register
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            restart_en_reg <= wds_pkg::WDS_REN_RST;
            second_pair_shutdown_level_reg <= wds_pkg::WDS_LVL_RST;
            first_pair_shutdown_level_reg <= wds_pkg::WDS_LVL_RST;
        end else if (wr_lane0 && aw_addr_reg == wds_pkg::WDS_ADDR_SDCTL) begin
            restart_en_reg <= wr_byte[wds_pkg::WDS_REN_BIT];
            second_pair_shutdown_level_reg <=
                wr_byte[wds_pkg::WDS_LB_LO +: wds_pkg::WDS_LVL_W];
            first_pair_shutdown_level_reg <=
                wr_byte[wds_pkg::WDS_LA_LO +: wds_pkg::WDS_LVL_W];
        end
    end

    // a live request always wins over a software clear or auto-restart
    always_comb begin
        shutdown_next = shutdown_reg;
        if (wr_lane0 && aw_addr_reg == wds_pkg::WDS_ADDR_SDCTL) begin
            shutdown_next = wr_byte[wds_pkg::WDS_SD_BIT];
        end
        if (restart_en_reg && !req_s) begin
            shutdown_next = 1'h0;
        end
        if (req_s) begin
            shutdown_next = 1'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shutdown_reg <= 1'h0;
        end else begin
            shutdown_reg <= shutdown_next;
        end
    end

    // ****************************************
    // shutdown sequencing
    // ****************************************
    assign wave_rise = wave_s && !wave_d_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wave_d_reg <= 1'h0;
        end else begin
            wave_d_reg <= wave_s;
        end
    end

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            wds_pkg::WDS_RUN: begin
                if (shutdown_reg) begin
                    state_next = wds_pkg::WDS_SHUT;
                end
            end
            wds_pkg::WDS_SHUT: begin
                if (!shutdown_reg) begin
                    state_next = wds_pkg::WDS_HOLD;
                end
            end
            wds_pkg::WDS_HOLD: begin
                if (shutdown_reg) begin
                    state_next = wds_pkg::WDS_SHUT;
                end else if (wave_rise) begin
                    state_next = wds_pkg::WDS_RUN;
                end
            end
            default: state_next = wds_pkg::WDS_RUN;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= wds_pkg::WDS_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // levels stay forced through the wait for the next rising input
    assign override = state_reg != wds_pkg::WDS_RUN;
    assign first_lvl = first_pair_shutdown_level_reg;
    assign second_lvl = second_pair_shutdown_level_reg;

    // ****************************************
    // output pins
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_output_pair <= 2'h0;
            first_output_pair_oe <= 2'h3;
        end else if (!override) begin
            first_output_pair <= {2{rise_db.delayed}};
            first_output_pair_oe <= 2'h3;
        end else begin
            // 00 falls back to the inactive level, polarity is handled outside
            first_output_pair <= {2{first_lvl == wds_pkg::WDS_LVL_HIGH}};
            first_output_pair_oe <=
                {2{first_lvl != wds_pkg::WDS_LVL_TRI}};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            second_output_pair <= 2'h0;
            second_output_pair_oe <= 2'h3;
        end else if (!override) begin
            second_output_pair <= {2{fall_db.delayed}};
            second_output_pair_oe <= 2'h3;
        end else begin
            // high for 11, low for 10 and 00, released (enable off) for 01
            second_output_pair <=
                {2{second_lvl == wds_pkg::WDS_LVL_HIGH}};
            second_output_pair_oe <= {2{second_lvl != wds_pkg::WDS_LVL_TRI}};
        end
    end

    // ****************************************
    // interrupt status and mask
    // ****************************************
    assign irq_event[wds_pkg::WDS_IRQ_SHUT] =
        state_reg != wds_pkg::WDS_SHUT && state_next == wds_pkg::WDS_SHUT;
    assign irq_event[wds_pkg::WDS_IRQ_RESUME] =
        state_reg != wds_pkg::WDS_RUN && state_next == wds_pkg::WDS_RUN;

    // write-one-to-clear, a new event in the same cycle stays set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= wds_pkg::WDS_IRQ_RST;
        end else if (wr_lane0 &&
                     aw_addr_reg == wds_pkg::WDS_ADDR_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg &
                             ~wr_byte[wds_pkg::WDS_IRQ_W-1:0]) | irq_event;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_event;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_reg <= wds_pkg::WDS_IRQ_RST;
        end else if (wr_lane0 &&
                     aw_addr_reg == wds_pkg::WDS_ADDR_IRQ_MASK) begin
            irq_mask_reg <= wr_byte[wds_pkg::WDS_IRQ_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'h0;
        end else begin
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    assign arready = !rvalid;
    assign rd_fire = arvalid && arready;

    always_comb begin
        rd_word = wds_pkg::WDS_ZERO_WORD;
        rd_hit = 1'h1;
        unique case (araddr)
            wds_pkg::WDS_ADDR_RISE: begin
                rd_word[wds_pkg::WDS_CNT_W-1:0] = rise_deadband_value_reg;
            end
            wds_pkg::WDS_ADDR_FALL: begin
                rd_word[wds_pkg::WDS_CNT_W-1:0] = fall_deadband_value_reg;
            end
            wds_pkg::WDS_ADDR_SDCTL: begin
                rd_word[wds_pkg::WDS_SD_BIT] = shutdown_reg;
                rd_word[wds_pkg::WDS_REN_BIT] = restart_en_reg;
                rd_word[wds_pkg::WDS_LB_LO +: wds_pkg::WDS_LVL_W] =
                    second_pair_shutdown_level_reg;
                rd_word[wds_pkg::WDS_LA_LO +: wds_pkg::WDS_LVL_W] =
                    first_pair_shutdown_level_reg;
            end
            wds_pkg::WDS_ADDR_IRQ_STAT: begin
                rd_word[wds_pkg::WDS_IRQ_W-1:0] = irq_stat_reg;
            end
            wds_pkg::WDS_ADDR_IRQ_MASK: begin
                rd_word[wds_pkg::WDS_IRQ_W-1:0] = irq_mask_reg;
            end
            default: begin
                rd_hit = 1'h0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'h0;
            rdata <= wds_pkg::WDS_ZERO_WORD;
            rresp <= wds_pkg::WDS_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid <= 1'h1;
            rdata <= rd_word;
            rresp <= rd_hit ? wds_pkg::WDS_RESP_OKAY
                            : wds_pkg::WDS_RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'h0;
        end
    end

endmodule

// ---- sim/wds_gate_drv.sv ----
// Purpose: gate-driver inputs seen by the power stage on both output pairs
// Assumes: each driver input has a pull-down
// Notes: a tri-stated pin reads low through the pull-down
`timescale 1ns/1ps
module wds_gate_drv (
    input wire logic [1:0] first_out,
    input wire logic [1:0] first_oe,
    input wire logic [1:0] second_out,
    input wire logic [1:0] second_oe,
    output logic [1:0] first_pin,
    output logic [1:0] second_pin
);
    // pull-down wins only while the block has released the pin
    assign first_pin = first_out & first_oe;
    assign second_pin = second_out & second_oe;
endmodule

// ---- sim/wds_top_assertions.sv ----
// Purpose: port-level checks on the dead-band and shutdown block
// Assumes: one clock, synchronous active-low reset
// Notes: register contents are not visible, so checks use bus traffic
`timescale 1ns/1ps
module wds_top_assertions #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic shutdown_req,
    input wire logic [1:0] first_output_pair,
    input wire logic [1:0] first_output_pair_oe,
    input wire logic [1:0] second_output_pair,
    input wire logic [1:0] second_output_pair_oe
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ****************************************
    // bus handshakes
    // ****************************************
    sequence wr_take;
        awvalid && awready && wvalid && wready && !bvalid;
    endsequence
    sequence wr_answer;
        !bvalid ##1 bvalid;
    endsequence
    sequence rd_take;
        arvalid && arready;
    endsequence

    wr_answer_a: assert property (wr_take |=> wr_answer)
        else $error("write answer late");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    rd_answer_a: assert property (rd_take |=> rvalid)
        else $error("read answer late");
    rdata_hold_a: assert property (rvalid && !rready
        |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read data dropped");
    ar_block_a: assert property (arready == !rvalid)
        else $error("read address accepted while busy");
    rd_unmapped_a: assert property (arvalid && arready
        && araddr > wds_pkg::WDS_ADDR_IRQ_MASK
        |=> rresp == wds_pkg::WDS_RESP_SLVERR && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    count_upper_a: assert property (arvalid && arready && (araddr ==
        wds_pkg::WDS_ADDR_RISE || araddr == wds_pkg::WDS_ADDR_FALL)
        |=> rdata[31:6] == 26'h000_0000)
        else $error("count upper bits not zero");

    // ****************************************
    // output pairs
    // ****************************************
    second_pair_a: assert property (second_output_pair[0] ==
        second_output_pair[1] && second_output_pair_oe[0] ==
        second_output_pair_oe[1])
        else $error("second pair bits differ");
    first_pair_a: assert property (first_output_pair[0] ==
        first_output_pair[1] && first_output_pair_oe[0] ==
        first_output_pair_oe[1])
        else $error("first pair bits differ");
    shut_hold_a: assert property (shutdown_req [*8] |->
        $stable(first_output_pair) && $stable(second_output_pair) &&
        $stable(first_output_pair_oe) && $stable(second_output_pair_oe))
        else $error("outputs move during shutdown");
endmodule

bind wds_top wds_top_assertions #(.ADDR_W(ADDR_W)) chk (.*);

// ---- sim/test_waveform_deadband_shutdown_ctrl.sv ----
// Purpose: register, dead-band and shutdown tests for the block
// Assumes: count registers are written before use
// Notes: dead-band is checked as a difference, so sync delay cancels
`timescale 1ns/1ps
module test_waveform_deadband_shutdown_ctrl;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, wave_in, shutdown_req, irq;
    logic [7:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic [3:0] wstrb;
    logic [31:0] wdata, rdata, rv;
    logic [1:0] bresp, rresp, wresp, rsp, fo, foe, so, soe, fp, sp, lb, la;
    int n_fail, compares, r0, r63, f0, f63;

    wds_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awprot(awprot), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(arprot), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .wave_in(wave_in), .shutdown_req(shutdown_req),
        .first_output_pair(fo), .first_output_pair_oe(foe),
        .second_output_pair(so), .second_output_pair_oe(soe), .irq(irq));
    wds_gate_drv drv (.first_out(fo), .first_oe(foe), .second_out(so),
        .second_oe(soe), .first_pin(fp), .second_pin(sp));

    always #50 aclk = ~aclk;

    // ****************************************
    // bus tasks
    // ****************************************
    // ready is sampled at the falling edge, where it is settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        b = 1'h0;
        while (!b) begin
            @(negedge aclk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            wresp = bresp;
            @(posedge aclk);
            if (aw) awvalid <= 1'h0;
            if (w) wvalid <= 1'h0;
        end
    endtask

    task automatic rd(input logic [7:0] a);
        logic ar, r;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        r = 1'h0;
        while (!r) begin
            @(negedge aclk);
            ar = arvalid && arready;
            r = rvalid;
            rv = rdata;
            rsp = rresp;
            @(posedge aclk);
            if (ar) arvalid <= 1'h0;
        end
    endtask

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    // cycles until the pair driven by this wave level goes high
    task automatic meas(input logic v, output int n);
        wave_in <= v;
        n = 0;
        while (n < 300 && (v ? fo : so) !== 2'h3) begin
            @(negedge aclk);
            n++;
        end
        @(posedge aclk);
    endtask

    task automatic do_reset;
        aresetn <= 1'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge aclk);
        n_fail++;
        finish_test;
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        aclk = 1'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {wave_in, shutdown_req} = 2'h0;
        {awaddr, araddr, wdata} = 48'h0000_0000_0000;
        {awprot, arprot} = 6'h00;
        wstrb = 4'hF;
        do_reset;
        rd(8'h08); chk("sdctl reset", 32'h0000_0014, rv);
        wr(8'h00, 32'hFFFF_FFFF); rd(8'h00);
        chk("rise count", 32'h0000_003F, rv);
        wr(8'h04, 32'h0000_00D5); rd(8'h04);
        chk("fall count", 32'h0000_0015, rv);
        do_reset;
        rd(8'h00); chk("rise kept", 32'h0000_003F, rv);
        rd(8'h04); chk("fall kept", 32'h0000_0015, rv);
        wr(8'h20, 32'h0000_0001); chk("unmapped wr", 32'h2, wresp);
        rd(8'h14); chk("unmapped rd", 32'h2, rsp);
        wr(8'h00, 32'h0000_0000); wr(8'h04, 32'h0000_0000);
        meas(1'h1, r0); chk("second off", 32'h0, so);
        meas(1'h0, f0); chk("first off", 32'h0, fo);
        wr(8'h00, 32'h0000_003F); wr(8'h04, 32'h0000_003F);
        meas(1'h1, r63); meas(1'h0, f63);
        chk("rise span", 32'd63, r63 - r0);
        chk("fall span", 32'd63, f63 - f0);
        wr(8'h10, 32'h0000_0001);
        for (int i = 0; i < 2; i++) begin
            lb = i ? 2'h2 : 2'h3;
            la = i ? 2'h2 : 2'h1;
            wave_in <= 1'h1;
            repeat (80) @(posedge aclk);
            wr(8'h08, {24'h00_0000, 2'h1, lb, la, 2'h0});
            rd(8'h08); chk("sdctl", {24'h00_0000, 2'h1, lb, la, 2'h0}, rv);
            shutdown_req <= 1'h1;
            repeat (10) @(posedge aclk);
            chk("second pin", i ? 32'h0 : 32'h3, sp);
            chk("second oe", 32'h3, soe);
            chk("first pin", 32'h0, fp);
            chk("first oe", i ? 32'h3 : 32'h0, foe);
            rd(8'h08); chk("status set", 32'h1, rv[7]);
            chk("irq on", 32'h1, irq);
            shutdown_req <= 1'h0;
            repeat (10) @(posedge aclk);
            rd(8'h08); chk("auto clear", 32'h0, rv[7]);
            chk("held pin", i ? 32'h0 : 32'h3, sp);
            chk("held oe", i ? 32'h3 : 32'h0, foe);
            wave_in <= 1'h0;
            repeat (80) @(posedge aclk);
            wave_in <= 1'h1;
            repeat (80) @(posedge aclk);
            chk("resumed", 32'h3, fp);
            chk("resumed oe", 32'h3, foe);
            wr(8'h0C, 32'h0000_0003);
        end
        wr(8'h08, 32'h0000_0028);
        shutdown_req <= 1'h1;
        repeat (10) @(posedge aclk);
        chk("irq set", 32'h1, irq);
        shutdown_req <= 1'h0;
        repeat (10) @(posedge aclk);
        rd(8'h08); chk("no restart", 32'h0000_00A8, rv);
        wr(8'h10, 32'h0000_0000); repeat (2) @(posedge aclk);
        chk("irq masked", 32'h0, irq);
        wr(8'h10, 32'h0000_0001); repeat (2) @(posedge aclk);
        chk("irq unmasked", 32'h1, irq);
        wr(8'h0C, 32'h0000_0001); repeat (2) @(posedge aclk);
        chk("irq cleared", 32'h0, irq);
        rd(8'h0C); chk("stat cleared", 32'h0, rv[0]);
        wr(8'h08, 32'h0000_0028);
        rd(8'h08); chk("sw clear", 32'h0000_0028, rv);
        finish_test;
    end
endmodule
